// [rtl/shrp_pkg.sv]
// package of constants for the serial host register port
package shrp_pkg;
   // =========================================================
   // frame layout
   localparam int INSTR_BITS = 5;
   localparam int ADDR_BITS = 11;
   localparam int DATA_BITS = 8;
   localparam int HDR_BITS = INSTR_BITS + ADDR_BITS;
   localparam int FRAME_BITS = HDR_BITS + DATA_BITS;
   localparam int CNT_W = 5;
   // position of the direction bit within the instruction
   localparam int DIR_POS = INSTR_BITS - 1;
   localparam logic [CNT_W-1:0] CNT_HDR_LAST = 5'h0F;
   localparam logic [CNT_W-1:0] CNT_FRAME_END = 5'h18;
   localparam logic [DATA_BITS-1:0] DATA_RESET = 8'h00;
   localparam logic [ADDR_BITS-1:0] ADDR_RESET = 11'h000;
   // =========================================================
   // phase of a transaction
   typedef enum logic [1:0] {
      SHRP_IDLE,
      SHRP_HDR,
      SHRP_READ,
      SHRP_WRITE
   } shrp_phase_t;
endpackage

// [rtl/shrp_port.sv]
// serial host register port: slave side of the host link
`timescale 1ns/1ps
module shrp_port (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // serial link pins, asynchronous to mclk_in
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // register side
   output logic [shrp_pkg::ADDR_BITS-1:0] reg_addr_out,
   output logic reg_rd_out,
   input wire logic [shrp_pkg::DATA_BITS-1:0] reg_rdata_in,
   output logic reg_wr_out,
   output logic [shrp_pkg::DATA_BITS-1:0] reg_wdata_out
);
   import shrp_pkg::*;

   // =========================================================
   // synchronisers
   logic [2:0] meta_r, meta_nxt;
   logic [2:0] sync_r, sync_nxt;
   logic cs_d_r, cs_d_nxt;
   logic sclk_d_r, sclk_d_nxt;

   // two flops per pin, plus one delay for edge finding
   always_comb begin
      meta_nxt = {cs_n_in, sclk_in, sdi_in};
      sync_nxt = meta_r;
      cs_d_nxt = sync_r[2];
      sclk_d_nxt = sync_r[1];
   end

   // register the chain; reset matches idle pins to avoid a false edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         meta_r <= 3'h5; // cs high, sclk low, sdi high
         sync_r <= 3'h5;
         cs_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         cs_d_r <= cs_d_nxt;
         sclk_d_r <= sclk_d_nxt;
      end
   end

   logic cs_n_s, sclk_s, sdi_s;
   logic cs_fall, cs_rise, sclk_rise, sclk_fall;
   // sdi is sampled with the same latency as sclk, so hold time holds
   assign cs_n_s = sync_r[2];
   assign sclk_s = sync_r[1];
   assign sdi_s = sync_r[0];
   assign cs_fall = cs_d_r & ~cs_n_s;
   assign cs_rise = ~cs_d_r & cs_n_s;
   assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_r;
   assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_r;

   // =========================================================
   // transaction engine
   shrp_phase_t phase_r, phase_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [HDR_BITS-1:0] hdr_r, hdr_nxt;
   logic [DATA_BITS-1:0] shd_r, shd_nxt;
   logic [ADDR_BITS-1:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic [DATA_BITS-1:0] wdata_r, wdata_nxt;
   logic sdo_r, sdo_nxt, oe_r, oe_nxt;
   logic [HDR_BITS-1:0] hdr_full;

   assign hdr_full = {hdr_r[HDR_BITS-2:0], sdi_s};

   // next state of the shifter; cs high overrides everything
   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      hdr_nxt = hdr_r;
      shd_nxt = shd_r;
      addr_nxt = addr_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      wdata_nxt = wdata_r;
      sdo_nxt = sdo_r;
      oe_nxt = oe_r;
      if (cs_n_s) begin
         phase_nxt = SHRP_IDLE;
         cnt_nxt = '0;
         oe_nxt = 1'b0;
         sdo_nxt = 1'b0;
      end else begin
         unique case (phase_r)
            SHRP_IDLE: begin
               if (cs_fall) begin
                  phase_nxt = SHRP_HDR;
                  cnt_nxt = '0;
               end
            end
            SHRP_HDR: begin
               if (sclk_rise) begin
                  hdr_nxt = hdr_full;
                  cnt_nxt = cnt_r + 5'h01;
                  if (cnt_r == CNT_HDR_LAST) begin
                     addr_nxt = hdr_full[ADDR_BITS-1:0];
                     if (hdr_full[ADDR_BITS+DIR_POS]) begin
                        phase_nxt = SHRP_READ;
                        rd_nxt = 1'b1;
                     end else begin
                        phase_nxt = SHRP_WRITE;
                     end
                  end
               end
            end
            SHRP_READ: begin
               // data fetched in the mclk cycles before sclk falls
               if (rd_r) begin
                  shd_nxt = reg_rdata_in;
               end
               if (sclk_fall && cnt_r != CNT_FRAME_END) begin
                  sdo_nxt = shd_r[DATA_BITS-1];
                  oe_nxt = 1'b1;
                  shd_nxt = {shd_r[DATA_BITS-2:0], 1'b0};
                  cnt_nxt = cnt_r + 5'h01;
               end else if (sclk_fall) begin
                  oe_nxt = 1'b0;
               end
            end
            SHRP_WRITE: begin
               if (sclk_rise && cnt_r != CNT_FRAME_END) begin
                  shd_nxt = {shd_r[DATA_BITS-2:0], sdi_s};
                  cnt_nxt = cnt_r + 5'h01;
                  if (cnt_r == CNT_FRAME_END - 5'h01) begin
                     wr_nxt = 1'b1;
                     wdata_nxt = {shd_r[DATA_BITS-2:0], sdi_s};
                  end
               end
            end
         endcase
      end
   end

   // register the transaction state
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         phase_r <= SHRP_IDLE;
         cnt_r <= '0;
         hdr_r <= '0;
         shd_r <= DATA_RESET;
         addr_r <= ADDR_RESET;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         wdata_r <= DATA_RESET;
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         hdr_r <= hdr_nxt;
         shd_r <= shd_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         wdata_r <= wdata_nxt;
         sdo_r <= sdo_nxt;
         oe_r <= oe_nxt;
      end
   end

   // outputs straight from flops
   assign sdo_out = sdo_r;
   assign sdo_oe_out = oe_r;
   assign reg_addr_out = addr_r;
   assign reg_rd_out = rd_r;
   assign reg_wr_out = wr_r;
   assign reg_wdata_out = wdata_r;

   // =========================================================
   // assertions
   // output must be released one cycle after chip select is seen high
   a_oe_cs_high: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      cs_n_s |=> !sdo_oe_out)
      else $error("sdo driven while chip select high");
   a_oe_only_read: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(sdo_oe_out) |-> $past(phase_r) == SHRP_READ)
      else $error("sdo enabled outside a read");
   a_sdo_on_fall: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      $changed(sdo_out) && !$past(cs_n_s) |-> $past(sclk_fall))
      else $error("sdo changed without falling sclk");
   a_wr_is_write: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      reg_wr_out |-> phase_r == SHRP_WRITE && cnt_r == CNT_FRAME_END)
      else $error("write strobe outside write phase");
   // the header register still holds the direction bit at the strobe
   a_rd_dir_bit: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      reg_rd_out |-> hdr_r[HDR_BITS-1])
      else $error("read strobe with direction bit zero");
   a_cs_idle: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      cs_n_s |=> phase_r == SHRP_IDLE && cnt_r == 5'h00)
      else $error("transaction not cleared by chip select");
   a_hdr_count: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      phase_r == SHRP_HDR && sclk_rise |=> cnt_r == $past(cnt_r) + 5'h01)
      else $error("header bit not counted");
   a_addr_hold: assert property (
      @(posedge mclk_in) disable iff (!rst_n_in)
      phase_r == SHRP_READ && $past(phase_r) == SHRP_READ
      |-> $stable(reg_addr_out))
      else $error("address moved during read data");
   // main scenarios: read, write, data out, cut header, cut write data
   c_read: cover property (@(posedge mclk_in) reg_rd_out);
   c_write: cover property (@(posedge mclk_in) reg_wr_out);
   c_sdo_on: cover property (@(posedge mclk_in) $rose(sdo_oe_out));
   c_abort: cover property (@(posedge mclk_in)
      phase_r == SHRP_HDR && cs_rise);
   c_wr_abort: cover property (@(posedge mclk_in)
      phase_r == SHRP_WRITE && cs_rise);
endmodule // shrp_port

// [dv/shrp_host_model.sv]
// host-side serial master model for the register port
`timescale 1ns/1ps
module shrp_host_model (
   // clock used only to pace the link
   input wire logic mclk_in,
   // serial link
   output logic cs_n_out,
   output logic sclk_out,
   output logic sdi_out,
   input wire logic sdo_in,
   input wire logic sdo_oe_in
);
   logic last_r = 1'b0;
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   // =========================================================
   // pacing: low 5 and high 3 cycles give the 32 ns link clock
   task automatic half(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // =========================================================
   // one frame, msb first; cut short after nb bits
   task automatic frame(input logic [23:0] w, input int nb,
                        output logic [7:0] rd);
      rd = 8'h00;
      // move off the sampling edge before chip select falls
      half(1);
      cs_n_out = 1'b0;
      for (int i = 23; i > 23 - nb; i--) begin
         sdi_out = w[i];
         half(5);
         sclk_out = 1'b1;
         // a released line reads as the inverse of its last level
         last_r = sdo_oe_in ? sdo_in : ~last_r;
         if (i < 8) rd[i] = last_r;
         half(3);
         sclk_out = 1'b0;
      end
      half(5);
      cs_n_out = 1'b1;
      half(6);
   endtask
endmodule // shrp_host_model

// [dv/shrp_port_tb_top.sv]
// self-checking bench for the serial host register port
`timescale 1ns/1ps
module shrp_port_tb_top;
   import shrp_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cs_n, sclk, sdi, sdo, sdo_oe, rd_p, wr_p;
   logic [10:0] addr;
   logic [10:0] aa [3];
   logic [7:0] rdata, wdata;
   logic [7:0] mem [2048];
   logic [7:0] exp_mem [2048];
   logic [19:0] exp_q [$];
   int bad_count = 0;
   int samples_checked = 0;
   always #2 mclk_in = ~mclk_in;
   initial foreach (mem[i]) begin
      mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
   end
   assign rdata = mem[addr];
   shrp_port i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo),
      .sdo_oe_out(sdo_oe), .reg_addr_out(addr), .reg_rd_out(rd_p),
      .reg_rdata_in(rdata), .reg_wr_out(wr_p), .reg_wdata_out(wdata));
   shrp_host_model i_host (.mclk_in(mclk_in), .cs_n_out(cs_n),
      .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
   task automatic check(input logic [19:0] seen, input logic [19:0] ex);
      samples_checked++;
      if (seen !== ex) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic results();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // =========================================================
   // register side: stores writes, scores every strobe
   always @(posedge mclk_in) begin
      if (wr_p === 1'b1) mem[addr] <= wdata;
      if (rd_p === 1'b1 || wr_p === 1'b1) begin
         // a strobe with nothing expected is always a mismatch
         if (exp_q.size() == 0) check({rd_p, addr, 8'h00}, 20'hFFFFF);
         else check({rd_p, addr, rd_p ? 8'h00 : wdata},
                    exp_q.pop_front());
      end
   end
   // one transfer; expectations noted before it starts
   task automatic xfer(input logic r, input logic [10:0] a,
                       input logic [7:0] d, input int nb);
      logic [7:0] rv;
      logic [3:0] lo;
      lo = 4'($urandom);
      if (nb == 24) exp_q.push_back({r, a, r ? 8'h00 : d});
      i_host.frame({r, lo, a, d}, nb, rv);
      if (r) check({12'h000, rv}, {12'h000, exp_mem[a]});
      if (!r && nb == 24) exp_mem[a] = d;
      repeat (4) @(posedge mclk_in);
      check({19'h0, sdo_oe}, 20'h0);
   endtask
   initial begin
      void'($urandom(32'h6b33d76b));
      repeat (2) @(posedge mclk_in);
      #1;
      rst_n_in = 1'b1;
      repeat (4) @(posedge mclk_in);
      // writes at both address ends and one random place
      for (int k = 0; k < 3; k++) begin
         aa[k] = (k == 2) ? 11'($urandom) : {11{k[0]}};
         xfer(1'b0, aa[k], 8'($urandom), 24);
      end
      $display("test writes done");
      foreach (aa[k]) xfer(1'b1, aa[k], 8'h00, 24);
      $display("test reads done");
      // chip select rising mid-header or mid-data must drop the write
      xfer(1'b0, aa[1], 8'($urandom), 10);
      xfer(1'b0, aa[0], 8'($urandom), 20);
      xfer(1'b1, aa[0], 8'h00, 24);
      $display("test abort done");
      repeat (8) @(posedge mclk_in);
      check({19'h0, exp_q.size() == 0}, 20'h1);
      results();
   end
   // watchdog: nine frames need about 1750 cycles
   initial begin
      #20000;
      bad_count++;
      results();
   end
endmodule // shrp_port_tb_top
